// ===== hw/pfc_host.sv
// host-side controller that drives a parallel nor flash through its pins
// Operation
// - host writes reset after timeout or command identification
// - elevated voltage id read uses select lines
// - sector address gives protection verify code
// - host holds id option high for maker on elevated voltage id reads only
// - identification also reachable by command sequence
// - command identification never uses elevated voltage
// - program is two unlocks, setup, address-data
// - polarity and timeout flags show program progress
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.svh"

module pfc_host #(
   parameter int POLL_MAX = `PFC_POLL_MAX
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire pfc_pkg::pfc_op_e cmd_op,
   input wire logic [19:0] cmd_addr,
   input wire logic cmd_lsb,
   input wire logic cmd_word,
   input wire logic [15:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic rsp_err,
   output logic [15:0] rsp_data,
   output logic [19:0] fl_addr,
   output logic [15:0] fl_dq_out,
   output logic [15:0] fl_dq_oe,
   input wire logic [15:0] fl_dq_in,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   output logic fl_byte_n,
   output logic fl_hv_en
);
   import pfc_pkg::*;

   localparam logic [2:0] ACC_CYC = 3'(`PFC_ACC_CYC);
   localparam logic [2:0] WP_CYC = 3'(`PFC_WP_CYC);
   localparam logic [11:0] POLL_LIM = 12'(POLL_MAX);

   pfc_state_s r; // registered state
   pfc_state_s n; // next state

   // bus cycle list of each operation
   function automatic pfc_step_s step_info(input pfc_op_e op, input logic [2:0] step,
                                           input logic [19:0] addr, input logic lsb,
                                           input logic [15:0] wdata);
      pfc_step_s s;
      s.wr = 1'b0;
      s.last = 1'b1;
      s.lsb = lsb;
      s.addr = addr;
      s.data = wdata;
      unique case (op)
         PFC_OP_PROG: begin
            // two unlocks, setup, then target address and data
            s.last = (step == 3'h5);
            unique case (step)
               3'h0: begin
                  s = '{1'b1, 1'b0, 1'b0, `PFC_UNLK1_ADDR, {8'h00, `PFC_UNLK1_DATA}};
               end
               3'h1: begin
                  s = '{1'b1, 1'b0, 1'b1, `PFC_UNLK2_ADDR, {8'h00, `PFC_UNLK2_DATA}};
               end
               3'h2: begin
                  s = '{1'b1, 1'b0, 1'b0, `PFC_UNLK1_ADDR, {8'h00, `PFC_PROG_DATA}};
               end
               3'h3: begin
                  s.wr = 1'b1;
               end
               3'h5: begin
                  s = '{1'b1, 1'b1, 1'b0, `PFC_UNLK1_ADDR, {8'h00, `PFC_RESET_DATA}};
               end
               default: begin
                  s.wr = 1'b0; // status poll of the target
               end
            endcase
         end
         PFC_OP_IDCMD: begin
            // unlock, autoselect, one id read, reset to leave
            s.last = (step == 3'h4);
            unique case (step)
               3'h0: begin
                  s = '{1'b1, 1'b0, 1'b0, `PFC_UNLK1_ADDR, {8'h00, `PFC_UNLK1_DATA}};
               end
               3'h1: begin
                  s = '{1'b1, 1'b0, 1'b1, `PFC_UNLK2_ADDR, {8'h00, `PFC_UNLK2_DATA}};
               end
               3'h2: begin
                  s = '{1'b1, 1'b0, 1'b0, `PFC_UNLK1_ADDR, {8'h00, `PFC_AUTOSEL_DATA}};
               end
               3'h4: begin
                  s = '{1'b1, 1'b1, 1'b0, `PFC_UNLK1_ADDR, {8'h00, `PFC_RESET_DATA}};
               end
               default: begin
                  s.wr = 1'b0; // id read at the user address
               end
            endcase
         end
         PFC_OP_IDHV: begin
            // select lines and sector address pass through; maker read sets id option
            if (addr[1:0] == 2'b00) begin
               s.addr[`PFC_ID_OPT_BIT] = 1'b1;
            end
         end
         PFC_OP_RESET: begin
            s = '{1'b1, 1'b1, 1'b0, `PFC_UNLK1_ADDR, {8'h00, `PFC_RESET_DATA}};
         end
         default: begin
            s.wr = 1'b0; // plain array read needs no command first
         end
      endcase
      return s;
   endfunction

   // load the pins for the current step of an operation
   function automatic pfc_state_s issue(input pfc_state_s c);
      pfc_state_s t;
      pfc_step_s s;
      t = c;
      s = step_info(c.op, c.step, c.addr, c.lsb, c.wdata);
      t.st = PFC_ST_SETUP;
      t.wr = s.wr;
      t.fl_addr = s.addr;
      t.fl_ce_n = 1'b0;
      t.fl_oe_n = 1'b1;
      t.fl_we_n = 1'b1;
      t.fl_hv_en = (c.op == PFC_OP_IDHV);
      t.cnt = s.wr ? WP_CYC : ACC_CYC;
      if (c.fl_byte_n) begin
         t.fl_dq_out = s.data;
         t.fl_dq_oe = s.wr ? 16'hffff : 16'h0000;
      end else begin
         t.fl_dq_out = {s.lsb, 7'h00, s.data[7:0]};
         t.fl_dq_oe = {1'b1, 7'h00, s.wr ? 8'hff : 8'h00};
      end
      return t;
   endfunction

   // next state: idle, address setup, strobe, hold and decide
   always_comb begin
      pfc_step_s cur; // bus cycle now on the pins
      cur = step_info(r.op, r.step, r.addr, r.lsb, r.wdata);
      n = r;
      n.rsp_valid = 1'b0;
      unique case (r.st)
         PFC_ST_IDLE: begin
            if (cmd_valid) begin
               n.op = cmd_op;
               n.addr = cmd_addr;
               n.lsb = cmd_lsb;
               n.wdata = cmd_wdata;
               n.fl_byte_n = cmd_word;
               n.step = 3'h0;
               n.poll = 12'h000;
               n.to_seen = 1'b0;
               n.rsp_err = 1'b0;
               n.cmd_ready = 1'b0;
               n = issue(n);
            end
         end
         PFC_ST_SETUP: begin
            // address settled, now drop the strobe
            n.fl_we_n = ~r.wr;
            n.fl_oe_n = r.wr;
            n.st = PFC_ST_STROBE;
         end
         PFC_ST_STROBE: begin
            n.cnt = r.cnt - 3'h1;
            if (r.cnt == 3'h1) begin
               n.fl_we_n = 1'b1;
               n.fl_oe_n = 1'b1;
               n.st = PFC_ST_HOLD;
               if (!r.wr) begin
                  n.rdata = r.fl_byte_n ? fl_dq_in : {8'h00, fl_dq_in[7:0]};
               end
            end
         end
         PFC_ST_HOLD: begin
            if (r.op == PFC_OP_PROG && r.step == 3'h4) begin
               // the device times its own pulses; only poll the flags
               if (r.rdata[`PFC_POLARITY_BIT] == r.wdata[`PFC_POLARITY_BIT]) begin
                  n.st = PFC_ST_IDLE;
                  n.fl_ce_n = 1'b1;
                  n.fl_dq_oe = 16'h0000;
                  n.rsp_valid = 1'b1;
                  n.cmd_ready = 1'b1;
               end else if (r.to_seen || r.poll == POLL_LIM) begin
                  // stuck zero or timeout: restore array read
                  n.rsp_err = 1'b1;
                  n.step = 3'h5;
                  n = issue(n);
               end else begin
                  n.to_seen = r.rdata[`PFC_TIMEOUT_BIT];
                  n.poll = r.poll + 12'h001;
                  n = issue(n);
               end
            end else if (cur.last) begin
               n.st = PFC_ST_IDLE;
               n.fl_ce_n = 1'b1;
               n.fl_dq_oe = 16'h0000;
               n.fl_hv_en = 1'b0;
               n.rsp_valid = 1'b1;
               n.cmd_ready = 1'b1;
            end else begin
               n.step = r.step + 3'h1;
               n = issue(n);
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= PFC_ST_IDLE;
         r.fl_ce_n <= 1'b1;
         r.fl_oe_n <= 1'b1;
         r.fl_we_n <= 1'b1;
         r.fl_byte_n <= 1'b1;
         r.cmd_ready <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign cmd_ready = r.cmd_ready;
   assign rsp_valid = r.rsp_valid;
   assign rsp_err = r.rsp_err;
   assign rsp_data = r.rdata;
   assign fl_addr = r.fl_addr;
   assign fl_dq_out = r.fl_dq_out;
   assign fl_dq_oe = r.fl_dq_oe;
   assign fl_ce_n = r.fl_ce_n;
   assign fl_oe_n = r.fl_oe_n;
   assign fl_we_n = r.fl_we_n;
   assign fl_byte_n = r.fl_byte_n;
   assign fl_hv_en = r.fl_hv_en;

   // checks on the pin sequences
   AST_PROG_SETUP: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r.st == PFC_ST_SETUP && r.op == PFC_OP_PROG && r.step == 3'h2)
      |-> (r.wr && r.fl_dq_out[7:0] == `PFC_PROG_DATA && r.fl_addr == `PFC_UNLK1_ADDR))
      else $error("program setup cycle wrong");
   AST_PROG_TARGET: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r.st == PFC_ST_SETUP && r.op == PFC_OP_PROG && r.step == 3'h3)
      |-> (r.wr && r.fl_addr == r.addr && r.fl_dq_out[7:0] == r.wdata[7:0]))
      else $error("program target cycle wrong");
   AST_WE_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(fl_we_n) |-> ##1 !fl_we_n ##1 fl_we_n)
      else $error("write strobe width wrong");
   AST_FAIL_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r.st == PFC_ST_HOLD && r.op == PFC_OP_PROG && r.step == 3'h4 && r.to_seen
       && r.rdata[7] != r.wdata[7])
      |=> (r.st == PFC_ST_SETUP && r.wr && r.fl_dq_out[7:0] == `PFC_RESET_DATA))
      else $error("no reset after timeout");
   AST_IDCMD_EXIT: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r.st == PFC_ST_HOLD && r.op == PFC_OP_IDCMD && r.step == 3'h3)
      |=> (r.wr && r.fl_dq_out[7:0] == `PFC_RESET_DATA) ##3 r.st == PFC_ST_HOLD)
      else $error("identification not left by reset");
   AST_HV_ONLY_IDHV: assert property (@(posedge core_clk) disable iff (!rst_n)
      fl_hv_en |-> (r.op == PFC_OP_IDHV && !fl_ce_n))
      else $error("elevated voltage outside hv id read");
   AST_HV_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r.st == PFC_ST_SETUP && r.op == PFC_OP_IDHV)
      |-> (fl_hv_en && fl_addr[6] == r.addr[6] && fl_addr[1:0] == r.addr[1:0]))
      else $error("id select lines wrong");
   AST_ID_OPTION: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r.st == PFC_ST_SETUP && r.op == PFC_OP_IDHV && r.addr[1:0] == 2'b00)
      |-> fl_addr[`PFC_ID_OPT_BIT])
      else $error("id option low on maker read");
   AST_POLL_DONE: assert property (@(posedge core_clk) disable iff (!rst_n)
      (r.st == PFC_ST_HOLD && r.op == PFC_OP_PROG && r.step == 3'h4
       && r.rdata[7] == r.wdata[7])
      |=> (rsp_valid && !rsp_err && cmd_ready))
      else $error("matching poll did not finish");
endmodule // pfc_host

`default_nettype wire

// ===== pkg/pfc_defines.svh
// constants for the parallel flash mode controller: timing, commands, pin fields
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

// clock period and bus timing in nanoseconds
`define PFC_CLK_NS 25
`define PFC_T_ACC_NS 70
`define PFC_T_WP_NS 35
// least times round up to whole clock cycles
`define PFC_ACC_CYC ((`PFC_T_ACC_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_WP_CYC ((`PFC_T_WP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
// status polls before a program is given up
`define PFC_POLL_MAX 4000

// command cycle data and word addresses
`define PFC_UNLK1_ADDR 20'h00555
`define PFC_UNLK2_ADDR 20'h002aa
`define PFC_UNLK1_DATA 8'haa
`define PFC_UNLK2_DATA 8'h55
`define PFC_PROG_DATA 8'ha0
`define PFC_AUTOSEL_DATA 8'h90
`define PFC_RESET_DATA 8'hf0

// status and address bit positions
`define PFC_POLARITY_BIT 7
`define PFC_TOGGLE_BIT 6
`define PFC_TIMEOUT_BIT 5
`define PFC_ID_OPT_BIT 8
`define PFC_HV_BIT 9

`endif

// ===== pkg/pfc_pkg.sv
// types shared by the parallel flash mode controller
`default_nettype none

package pfc_pkg;
   // user operations
   typedef enum logic [2:0] {
      PFC_OP_READ,
      PFC_OP_PROG,
      PFC_OP_IDCMD,
      PFC_OP_IDHV,
      PFC_OP_RESET
   } pfc_op_e;

   // bus cycle phases
   typedef enum logic [1:0] {
      PFC_ST_IDLE,
      PFC_ST_SETUP,
      PFC_ST_STROBE,
      PFC_ST_HOLD
   } pfc_state_e;

   // one bus cycle of an operation
   typedef struct packed {
      logic wr;
      logic last;
      logic lsb;
      logic [19:0] addr;
      logic [15:0] data;
   } pfc_step_s;

   // whole controller state
   typedef struct packed {
      pfc_state_e st;
      pfc_op_e op;
      logic [2:0] step;
      logic [2:0] cnt;
      logic [11:0] poll;
      logic to_seen;
      logic wr;
      logic [19:0] addr;
      logic lsb;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [19:0] fl_addr;
      logic [15:0] fl_dq_out;
      logic [15:0] fl_dq_oe;
      logic fl_ce_n;
      logic fl_oe_n;
      logic fl_we_n;
      logic fl_byte_n;
      logic fl_hv_en;
      logic cmd_ready;
      logic rsp_valid;
      logic rsp_err;
   } pfc_state_s;
endpackage

`default_nettype wire

// ===== test/pfc_flash_model.sv
// behavioural model of the parallel nor flash seen by the host controller
`timescale 1ns/1ps
`default_nettype none

module pfc_flash_model #(
   parameter logic [15:0] MAKER_CODE = 16'h00a5, // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h2b6e, // arbitrary value
   parameter logic [7:0] CONFIG_CODE = 8'h3c, // arbitrary value
   parameter logic [7:0] LOCKED_SECTOR = 8'h05
) (
   input wire logic [19:0] fl_addr,
   input wire logic [15:0] fl_dq_out,
   input wire logic [15:0] fl_dq_oe,
   input wire logic fl_ce_n,
   input wire logic fl_oe_n,
   input wire logic fl_we_n,
   input wire logic fl_byte_n,
   input wire logic fl_hv_en,
   input wire logic [3:0] busy_polls,
   output logic [15:0] fl_dq_in
);
   logic [15:0] mem [256]; // array aliased on the low address bits
   logic [1:0] seq; // unlock cycles seen
   logic arm; // program setup taken
   logic id_mode; // command identification active
   logic busy; // embedded program running
   logic fail; // program stuck on a zero to one attempt
   logic tgl; // toggle flag
   logic [3:0] polls; // status reads left before done
   logic [7:0] tgt; // low byte being programmed
   logic [15:0] float_q; // pattern on released lines
   logic [15:0] rd; // value the device would drive
   logic [15:0] mask; // lines the device drives
   logic [15:0] want; // word after program
   logic lsb; // byte address lowest bit from the shared line

   // power-up contents, array read with no command
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 16'hf0f0 ^ 16'(i);
      {seq, arm, id_mode, busy, fail, tgl, polls, tgt} = '0;
      float_q = 16'h5a5a;
   end

   assign lsb = fl_dq_oe[15] ? fl_dq_out[15] : float_q[15];

   // read value and drive mask
   always_comb begin
      rd = fl_byte_n ? mem[fl_addr[7:0]] : {8'h00, lsb ? mem[fl_addr[7:0]][15:8]
                                                         : mem[fl_addr[7:0]][7:0]};
      if (id_mode || fl_hv_en) begin
         case (fl_addr[1:0])
            2'b00: rd = fl_addr[8] ? MAKER_CODE : {8'h00, CONFIG_CODE};
            2'b01: rd = PART_CODE;
            2'b10: rd = {15'h0000, fl_addr[19:12] == LOCKED_SECTOR};
            default: rd = 16'h0000;
         endcase
      end else if (busy) begin
         rd = {8'h00, ~tgt[7], tgl, fail, 5'h00};
      end
      mask = (fl_ce_n || fl_oe_n) ? 16'h0000 : (fl_byte_n ? 16'hffff : 16'h00ff);
   end

   // released lines show a pattern that flips on every read
   assign fl_dq_in = (fl_dq_oe & fl_dq_out) | (~fl_dq_oe & ((mask & rd) | (~mask & float_q)));

   // end of a read strobe advances status
   always @(posedge fl_oe_n) begin
      if (!fl_ce_n) begin
         tgl <= ~tgl;
         float_q <= ~float_q;
         if (busy && !fail) begin
            if (polls <= 4'h1) busy <= 1'b0;
            polls <= polls - 4'h1;
         end
      end
   end

   // command interface, taken at the end of the write strobe
   always @(posedge fl_we_n) begin
      want = fl_byte_n ? fl_dq_out : (lsb ? {fl_dq_out[7:0], mem[fl_addr[7:0]][7:0]}
                                          : {mem[fl_addr[7:0]][15:8], fl_dq_out[7:0]});
      if (fl_ce_n || (busy && !(fail && fl_dq_out[7:0] == 8'hf0))) begin
         seq <= seq;
      end else if (fl_dq_out[7:0] == 8'hf0 && !arm) begin
         {seq, id_mode, busy, fail} <= '0;
      end else if (arm) begin
         mem[fl_addr[7:0]] <= mem[fl_addr[7:0]] & want;
         fail <= (mem[fl_addr[7:0]] & want) != want;
         busy <= (busy_polls != 4'h0) || ((mem[fl_addr[7:0]] & want) != want);
         polls <= busy_polls;
         tgt <= fl_dq_out[7:0];
         arm <= 1'b0;
      end else if (seq == 2'd0 && fl_addr[10:0] == 11'h555 && fl_dq_out[7:0] == 8'haa) begin
         seq <= 2'd1;
      end else if (seq == 2'd1 && fl_addr[10:0] == 11'h2aa && fl_dq_out[7:0] == 8'h55) begin
         seq <= 2'd2;
      end else if (seq == 2'd2) begin
         arm <= fl_dq_out[7:0] == 8'ha0;
         id_mode <= fl_dq_out[7:0] == 8'h90;
         seq <= 2'd0;
      end else begin
         seq <= 2'd0;
      end
   end
endmodule // pfc_flash_model

`default_nettype wire

// ===== test/pfc_host_tb.sv
// self-checking testbench of the flash host controller against the flash model
`timescale 1ns/1ps
`default_nettype none

module pfc_host_tb;
   import pfc_pkg::*;
   localparam logic [15:0] MK = 16'h00a5; // arbitrary value
   localparam logic [15:0] PT = 16'h2b6e; // arbitrary value
   localparam logic [7:0] CF = 8'h3c; // arbitrary value
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   pfc_op_e cmd_op = PFC_OP_READ;
   logic [19:0] cmd_addr = '0;
   logic cmd_lsb = 1'b0;
   logic cmd_word = 1'b1;
   logic [15:0] cmd_wdata = '0;
   logic cmd_ready, rsp_valid, rsp_err, fl_ce_n, fl_oe_n, fl_we_n, fl_byte_n, fl_hv_en;
   logic [15:0] rsp_data, fl_dq_out, fl_dq_oe, fl_dq_in;
   logic [19:0] fl_addr;
   logic [3:0] busy_polls = 4'h3; // model program length in status reads
   int errors = 0;
   int checks_done = 0;
   int we_cnt = 0; // write strobes seen
   int hv_cnt = 0; // cycles with elevated voltage applied

   pfc_host #(.POLL_MAX(8)) DUT (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_lsb(cmd_lsb), .cmd_word(cmd_word),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
      .rsp_data(rsp_data), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
      .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
      .fl_byte_n(fl_byte_n), .fl_hv_en(fl_hv_en));

   pfc_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT), .CONFIG_CODE(CF)) flash (
      .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_byte_n(fl_byte_n), .fl_hv_en(fl_hv_en),
      .busy_polls(busy_polls), .fl_dq_in(fl_dq_in));

   // 40 mhz clock
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   // pin activity counters
   always @(negedge fl_we_n) we_cnt++;
   always @(posedge core_clk) if (fl_hv_en === 1'b1) hv_cnt++;

   // expected power-up contents
   function automatic logic [15:0] init(input logic [19:0] a);
      return 16'hf0f0 ^ {8'h00, a[7:0]};
   endfunction

   // one comparison
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      checks_done++;
      if (got !== ex) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, ex, got);
      end
   endtask

   // one user operation, waits for its response pulse
   task automatic op(input pfc_op_e o, input logic [19:0] a, input logic l, input logic w,
                     input logic [15:0] d);
      int n;
      n = 0;
      cmd_valid = 1'b1;
      cmd_op = o;
      cmd_addr = a;
      cmd_lsb = l;
      cmd_word = w;
      cmd_wdata = d;
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 400) begin
         errors++;
         $display("unexpected response: expected 1 seen 0");
      end
   endtask

   // verdict and end of run
   task automatic summarize;
      if (errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // idle pins after reset, then word and byte reads
   task automatic t_reads;
      chk("idle pins", 16'h003e, {10'h000, cmd_ready, fl_ce_n, fl_oe_n, fl_we_n, fl_byte_n, fl_hv_en});
      chk("idle drive", 16'h0000, fl_dq_oe);
      op(PFC_OP_READ, 20'h00005, 1'b0, 1'b1, 16'h0000);
      chk("word read", init(20'h00005), rsp_data);
      op(PFC_OP_READ, 20'h00005, 1'b1, 1'b0, 16'h0000);
      chk("byte read hi", init(20'h00005) >> 8, rsp_data);
      op(PFC_OP_READ, 20'h00005, 1'b0, 1'b0, 16'h0000);
      chk("byte read lo", init(20'h00005) & 16'h00ff, rsp_data);
   endtask

   // slow, prompt and byte programs, then a zero to one attempt
   task automatic t_prog;
      int w0;
      w0 = we_cnt;
      op(PFC_OP_PROG, 20'h01030, 1'b0, 1'b1, 16'h3080);
      chk("prog err", 16'h0000, {15'h0000, rsp_err});
      chk("prog writes", 16'h0004, 16'(we_cnt - w0));
      busy_polls = 4'h0;
      op(PFC_OP_PROG, 20'h00003, 1'b0, 1'b1, 16'h7073);
      op(PFC_OP_PROG, 20'h00040, 1'b1, 1'b0, 16'h0030);
      busy_polls = 4'h2;
      op(PFC_OP_READ, 20'h01030, 1'b0, 1'b1, 16'h0000);
      chk("prog data", 16'h3080, rsp_data);
      op(PFC_OP_READ, 20'h00003, 1'b0, 1'b1, 16'h0000);
      chk("prog low", 16'h7073, rsp_data);
      op(PFC_OP_READ, 20'h00040, 1'b0, 1'b1, 16'h0000);
      chk("prog byte", 16'h30b0, rsp_data);
      w0 = we_cnt;
      op(PFC_OP_PROG, 20'h00011, 1'b0, 1'b1, 16'h000f);
      chk("bad prog err", 16'h0001, {15'h0000, rsp_err});
      chk("bad prog writes", 16'h0005, 16'(we_cnt - w0));
      op(PFC_OP_READ, 20'h00011, 1'b0, 1'b1, 16'h0000);
      chk("bad prog data", init(20'h11) & 16'h000f, rsp_data);
   endtask

   // identification by command and by elevated voltage
   task automatic t_ident;
      int h0;
      h0 = hv_cnt;
      op(PFC_OP_IDCMD, 20'h00100, 1'b0, 1'b1, 16'h0000);
      chk("cmd maker", MK, rsp_data);
      op(PFC_OP_IDCMD, 20'h00000, 1'b0, 1'b1, 16'h0000);
      chk("cmd config", {8'h00, CF}, rsp_data);
      op(PFC_OP_IDCMD, 20'h00001, 1'b0, 1'b1, 16'h0000);
      chk("cmd part", PT, rsp_data);
      chk("cmd no hv", 16'h0000, 16'(hv_cnt - h0));
      op(PFC_OP_IDHV, 20'h00000, 1'b0, 1'b1, 16'h0000);
      chk("hv maker", MK, rsp_data);
      op(PFC_OP_IDHV, 20'h00001, 1'b0, 1'b1, 16'h0000);
      chk("hv part", PT, rsp_data);
      op(PFC_OP_IDHV, 20'h05002, 1'b0, 1'b1, 16'h0000);
      chk("hv locked", 16'h0001, rsp_data);
      op(PFC_OP_IDHV, 20'h06002, 1'b0, 1'b1, 16'h0000);
      chk("hv open", 16'h0000, rsp_data);
      op(PFC_OP_RESET, 20'h00000, 1'b0, 1'b1, 16'h0000);
      chk("reset err", 16'h0000, {15'h0000, rsp_err});
      op(PFC_OP_READ, 20'h00005, 1'b0, 1'b1, 16'h0000);
      chk("array again", init(20'h00005), rsp_data);
   endtask

   // reset in mid-read: pins go idle, the next read still works
   task automatic t_rst;
      cmd_valid = 1'b1;
      cmd_op = PFC_OP_READ;
      cmd_addr = 20'h00007;
      cmd_lsb = 1'b0;
      cmd_word = 1'b1;
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      rst_n = 1'b0;
      #1;
      chk("reset pins", 16'h003e, {10'h000, cmd_ready, fl_ce_n, fl_oe_n, fl_we_n, fl_byte_n, fl_hv_en});
      chk("reset drive", 16'h0000, fl_dq_oe);
      repeat (2) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      op(PFC_OP_READ, 20'h00007, 1'b0, 1'b1, 16'h0000);
      chk("read after reset", init(20'h00007), rsp_data);
   endtask

   // watchdog
   initial begin
      #2000000;
      errors++;
      summarize();
   end

   // main sequence
   initial begin
      repeat (2) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      t_reads();
      t_prog();
      t_ident();
      t_rst();
      summarize();
   end
endmodule // pfc_host_tb

`default_nettype wire
